// ---- rtl/pcu_privilege_check.v ----
// Privilege check unit: levels, I/O privilege, transfers, modes
//
// Operation
// - Levels 0..3, 0 most privileged; real mode runs at level 0.
// - cur_priv kept in hidden code segment state, equals code segment desc_priv.
// - eff_priv is the numerically larger of req_priv and cur_priv.
// - Memory access allowed only if eff_priv <= desc_priv, else fault.
// - Protected mode: CLI, STI, I/O instructions and IF changes are I/O-privilege sensitive.
// - io_priv_level lives in flags_register bits 13:12; only level 0 sets it.
// - Sensitive operations run unchecked when cur_priv <= io_priv_level.
// - cur_priv above io_priv_level with 16-bit task segment: always fault.
// - With 32-bit task segment consult port bitmap for I/O; others fault.
// - cur_priv changes only through gates or task switches; the code also loads it from chk_target_priv on RET and IRET returns.
// - Wrong descriptor type for a transfer raises a fault.
// - Code segments same/outward, call gate inward, INTERRUPT_DESCRIPTOR_TABLE gates for interrupts.
// - Task switch via task segment in GLOBAL_DESCRIPTOR_TABLE, or task gate; INTERRUPT_DESCRIPTOR_TABLE for interrupts.
// - Inward transfer loads stack for target level, saves old; return restores.
// - Gate usable only if eff_priv <= gate desc_priv, which exceptions skip; target never less privileged.
// - Real mode after reset; protected mode when protect_enable_bit set.
// - virtual_8086_mode tasks run at level 3; software sets limits.
// - virtual_8086_mode address is segment times 16 plus offset.
// - Paging allowed in virtual_8086_mode to relocate its space.
// - All protected checks apply in virtual_8086_mode; privileged instructions fault.
// - virtual_8086_mode: CLI, INT n, IRET, POPF, PUSHF, STI sensitive.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "pcu_defines.vh"

module pcu_privilege_check (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        chk_valid,
  input  wire [3:0]  chk_op,
  input  wire [1:0]  chk_req_priv,
  input  wire [1:0]  chk_desc_priv,
  input  wire [2:0]  chk_desc_type,
  input  wire [1:0]  chk_table,
  input  wire [1:0]  chk_target_priv,
  input  wire [9:0]  chk_port,
  input  wire [15:0] chk_seg,
  input  wire [15:0] chk_offset,
  input  wire [31:0] chk_old_sp,
  input  wire [15:0] chk_old_ss,
  output reg         res_valid,
  output reg         res_allow,
  output reg         res_gp_fault,
  output reg         res_task_switch,
  output reg         res_stack_load,
  output reg         res_stack_push,
  output reg  [31:0] res_sp,
  output reg  [15:0] res_ss,
  output reg  [20:0] res_lin_addr,
  output reg  [1:0]  res_cur_priv,
  output reg         res_prot_mode,
  output reg         res_v86_mode,
  output reg         res_page_en
);

  // Architectural state
  reg [31:0] ctrl0_r;
  reg [31:0] flags_r;
  reg        tss32_r;
  reg [1:0]  cur_priv_r;
  reg [31:0] stk_sp_r [0:2];
  reg [15:0] stk_ss_r [0:2];
  reg [31:0] saved_sp_r;
  reg [15:0] saved_ss_r;
  reg [31:0] bitmap_r [0:31];

  // Larger of two levels
  function [1:0] pcu_max;
    input [1:0] a;
    input [1:0] b;
    begin
      pcu_max = (a > b) ? a : b;
    end
  endfunction

  // Descriptor table is global or local
  function pcu_gl_table;
    input [1:0] t;
    begin
      pcu_gl_table = (t == `PCU_TB_GLOBAL) || (t == `PCU_TB_LOCAL);
    end
  endfunction

  wire       prot_mode = ctrl0_r[`PCU_PROT_EN_BIT];
  wire       v86_mode  = prot_mode & flags_r[`PCU_VM_BIT];
  wire [1:0] io_priv_level      = flags_r[`PCU_IO_PRIV_LEVEL_LSB+1:`PCU_IO_PRIV_LEVEL_LSB];
  wire       nt_flag   = flags_r[`PCU_NT_BIT];
  // Level the checks run at: 0 in real mode, 3 in V86
  wire [1:0] run_priv  = !prot_mode ? 2'h0 :
                         v86_mode ? `PCU_PRIV_MAX :
                         cur_priv_r;
  wire [1:0] eff_priv  = pcu_max(chk_req_priv, run_priv);
  wire       io_ok     = run_priv <= io_priv_level;
  wire       port_free = ~bitmap_r[chk_port[9:5]][chk_port[4:0]];
  wire [1:0] tgt_idx   = (chk_target_priv == 2'h3) ? 2'h2 : chk_target_priv;

  // Check decision
  reg        allow_nxt;
  reg        tsw_nxt;
  reg        load_nxt;
  reg        ret_nxt;
  reg        set_priv_nxt;
  always @* begin
    allow_nxt    = 1'b0;
    tsw_nxt      = 1'b0;
    load_nxt     = 1'b0;
    ret_nxt      = 1'b0;
    set_priv_nxt = 1'b0;
    case (chk_op)
      `PCU_OP_MEM: begin
        allow_nxt = !prot_mode || (eff_priv <= chk_desc_priv);
      end
      `PCU_OP_IO: begin
        if (!prot_mode || io_ok) begin
          allow_nxt = 1'b1;
        end else if (tss32_r) begin
          allow_nxt = port_free;
        end else begin
          allow_nxt = 1'b0;
        end
      end
      `PCU_OP_IFSENS: begin
        allow_nxt = !prot_mode || io_ok;
      end
      `PCU_OP_FLAGSPP: begin
        allow_nxt = !v86_mode || io_ok;
      end
      `PCU_OP_PRIV: begin
        allow_nxt = (run_priv == 2'h0);
      end
      `PCU_OP_JMP, `PCU_OP_CALL: begin
        if (!prot_mode) begin
          allow_nxt = 1'b1;
        end else if (chk_desc_type == `PCU_DT_CODE) begin
          allow_nxt = pcu_gl_table(chk_table) &&
                      (chk_desc_priv == run_priv);
        end else if (chk_desc_type == `PCU_DT_CGATE &&
                     chk_op == `PCU_OP_CALL) begin
          allow_nxt = pcu_gl_table(chk_table) &&
                      (eff_priv <= chk_desc_priv) &&
                      (chk_target_priv <= run_priv);
          load_nxt  = chk_target_priv < run_priv;
          set_priv_nxt = 1'b1;
        end else if (chk_desc_type == `PCU_DT_TSS) begin
          allow_nxt = (chk_table == `PCU_TB_GLOBAL) &&
                      (eff_priv <= chk_desc_priv);
          tsw_nxt   = 1'b1;
          set_priv_nxt = 1'b1;
        end else if (chk_desc_type == `PCU_DT_TASKGATE) begin
          allow_nxt = pcu_gl_table(chk_table) &&
                      (eff_priv <= chk_desc_priv);
          tsw_nxt   = 1'b1;
          set_priv_nxt = 1'b1;
        end else begin
          allow_nxt = 1'b0;
        end
      end
      `PCU_OP_RET, `PCU_OP_IRET: begin
        if (!prot_mode) begin
          allow_nxt = !(chk_op == `PCU_OP_IRET && v86_mode);
        end else if (chk_op == `PCU_OP_IRET && v86_mode && !io_ok) begin
          allow_nxt = 1'b0;
        end else if (chk_op == `PCU_OP_IRET && nt_flag) begin
          allow_nxt = (chk_desc_type == `PCU_DT_TASKGATE) &&
                      (chk_table == `PCU_TB_INTR);
          tsw_nxt   = 1'b1;
          set_priv_nxt = 1'b1;
        end else begin
          allow_nxt = (chk_desc_type == `PCU_DT_CODE) &&
                      pcu_gl_table(chk_table) &&
                      (chk_target_priv >= run_priv);
          ret_nxt   = chk_target_priv > run_priv;
          set_priv_nxt = 1'b1;
        end
      end
      `PCU_OP_INTN, `PCU_OP_INTX, `PCU_OP_EXC: begin
        if (!prot_mode) begin
          allow_nxt = 1'b1;
        end else if (chk_op == `PCU_OP_INTN && v86_mode && !io_ok) begin
          allow_nxt = 1'b0;
        end else if (chk_table != `PCU_TB_INTR) begin
          allow_nxt = 1'b0;
        end else if (chk_desc_type == `PCU_DT_TGATE ||
                     chk_desc_type == `PCU_DT_IGATE) begin
          allow_nxt = ((chk_op == `PCU_OP_EXC) ||
                       (eff_priv <= chk_desc_priv)) &&
                      (chk_target_priv <= run_priv);
          load_nxt  = chk_target_priv < run_priv;
          set_priv_nxt = 1'b1;
        end else if (chk_desc_type == `PCU_DT_TASKGATE) begin
          allow_nxt = (chk_op == `PCU_OP_EXC) ||
                      (eff_priv <= chk_desc_priv);
          tsw_nxt   = 1'b1;
          set_priv_nxt = 1'b1;
        end else begin
          allow_nxt = 1'b0;
        end
      end
      `PCU_OP_ADDR: begin
        allow_nxt = 1'b1;
      end
      default: begin
        allow_nxt = 1'b0;
      end
    endcase
  end

  // Register write decode
  wire wr_ctrl0  = ce & reg_wr & (reg_addr == `PCU_REG_CTRL0);
  wire wr_flags  = ce & reg_wr & (reg_addr == `PCU_REG_FLAGS);
  wire wr_tsscfg = ce & reg_wr & (reg_addr == `PCU_REG_TSSCFG);
  wire wr_bitmap = ce & reg_wr & (reg_addr[7:5] == 3'h1);
  wire take      = ce & chk_valid;
  wire commit    = take & allow_nxt;

  // Control, flags and privilege state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl0_r    <= `PCU_CTRL0_RST;
      flags_r    <= `PCU_FLAGS_RST;
      tss32_r    <= 1'b0;
      cur_priv_r <= 2'h0;
      saved_sp_r <= 32'h0000_0000;
      saved_ss_r <= 16'h0000;
    end else begin
      if (wr_ctrl0) begin
        ctrl0_r <= reg_wdata;
      end
      if (wr_flags) begin
        flags_r[31:14] <= reg_wdata[31:14];
        flags_r[11:0]  <= reg_wdata[11:0];
        if (run_priv == 2'h0) begin
          flags_r[13:12] <= reg_wdata[13:12];
        end
      end
      if (wr_tsscfg) begin
        tss32_r <= reg_wdata[`PCU_TSS32_BIT];
      end
      if (commit && set_priv_nxt && prot_mode && !v86_mode) begin
        cur_priv_r <= chk_target_priv;
      end
      if (commit && load_nxt) begin
        saved_sp_r <= chk_old_sp;
        saved_ss_r <= chk_old_ss;
      end
    end
  end

  // Stack pointers per inner level and port bitmap
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_stk
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          stk_sp_r[gi] <= 32'h0000_0000;
          stk_ss_r[gi] <= 16'h0000;
        end else if (ce && reg_wr) begin
          if (reg_addr == `PCU_REG_STK_SP0 + gi) begin
            stk_sp_r[gi] <= reg_wdata;
          end
          if (reg_addr == `PCU_REG_STK_SS0 + gi) begin
            stk_ss_r[gi] <= reg_wdata[15:0];
          end
        end
      end
    end
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_map
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          bitmap_r[gi] <= 32'hFFFF_FFFF;
        end else if (wr_bitmap && reg_addr[4:0] == gi) begin
          bitmap_r[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  // Register read data, one cycle after the strobe
  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (reg_addr)
      `PCU_REG_CTRL0:    rd_nxt = ctrl0_r;
      `PCU_REG_FLAGS:    rd_nxt = flags_r;
      `PCU_REG_STATUS:   rd_nxt = {28'h000_0000, v86_mode, prot_mode, run_priv};
      `PCU_REG_TSSCFG:   rd_nxt = {31'h0000_0000, tss32_r};
      `PCU_REG_SAVED_SP: rd_nxt = saved_sp_r;
      default: begin
        if (reg_addr[7:5] == 3'h1) begin
          rd_nxt = bitmap_r[reg_addr[4:0]];
        end else if (reg_addr >= `PCU_REG_STK_SP0 &&
                     reg_addr < `PCU_REG_STK_SP0 + 8'h03) begin
          rd_nxt = stk_sp_r[reg_addr[1:0]];
        end else if (reg_addr >= `PCU_REG_STK_SS0 &&
                     reg_addr < `PCU_REG_STK_SS0 + 8'h03) begin
          rd_nxt = {16'h0000, stk_ss_r[reg_addr[1:0]]};
        end
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_nxt : 32'h0000_0000;
    end
  end

  // Check results, one cycle after the request
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      res_valid       <= 1'b0;
      res_allow       <= 1'b0;
      res_gp_fault    <= 1'b0;
      res_task_switch <= 1'b0;
      res_stack_load  <= 1'b0;
      res_stack_push  <= 1'b0;
      res_sp          <= 32'h0000_0000;
      res_ss          <= 16'h0000;
      res_lin_addr    <= 21'h00_0000;
      res_cur_priv    <= 2'h0;
      res_prot_mode   <= 1'b0;
      res_v86_mode    <= 1'b0;
      res_page_en     <= 1'b0;
    end else if (ce) begin
      res_valid       <= chk_valid;
      res_allow       <= take & allow_nxt;
      res_gp_fault    <= take & ~allow_nxt;
      res_task_switch <= commit & tsw_nxt;
      res_stack_load  <= commit & (load_nxt | ret_nxt);
      res_stack_push  <= commit & load_nxt;
      if (commit && load_nxt) begin
        res_sp <= stk_sp_r[tgt_idx];
        res_ss <= stk_ss_r[tgt_idx];
      end else if (commit && ret_nxt) begin
        res_sp <= saved_sp_r;
        res_ss <= saved_ss_r;
      end
      res_lin_addr    <= {1'b0, chk_seg, 4'h0} + {5'h00, chk_offset};
      res_cur_priv    <= run_priv;
      res_prot_mode   <= prot_mode;
      res_v86_mode    <= v86_mode;
      res_page_en     <= ctrl0_r[`PCU_PAGE_EN_BIT];
    end
  end

endmodule // pcu_privilege_check

// ---- rtl/pcu_defines.vh ----
// Constants for the privilege check unit
`ifndef PCU_DEFINES_VH
`define PCU_DEFINES_VH
// Register indices
`define PCU_REG_CTRL0     8'h00
`define PCU_REG_FLAGS     8'h01
`define PCU_REG_STATUS    8'h02
`define PCU_REG_TSSCFG    8'h03
`define PCU_REG_STK_SP0   8'h04
`define PCU_REG_STK_SS0   8'h08
`define PCU_REG_SAVED_SP  8'h0C
`define PCU_REG_BITMAP0   8'h20
// Field positions
`define PCU_PROT_EN_BIT   0
`define PCU_PAGE_EN_BIT   31
`define PCU_IF_BIT        9
`define PCU_IO_PRIV_LEVEL_LSB      12
`define PCU_NT_BIT        14
`define PCU_VM_BIT        17
`define PCU_TSS32_BIT     0
// Reset values
`define PCU_CTRL0_RST     32'h0000_0000
`define PCU_FLAGS_RST     32'h0000_0002
`define PCU_PRIV_MAX      2'h3
// Operation codes
`define PCU_OP_MEM        4'h0
`define PCU_OP_IO         4'h1
`define PCU_OP_IFSENS     4'h2
`define PCU_OP_FLAGSPP    4'h3
`define PCU_OP_PRIV       4'h4
`define PCU_OP_JMP        4'h5
`define PCU_OP_CALL       4'h6
`define PCU_OP_RET        4'h7
`define PCU_OP_IRET       4'h8
`define PCU_OP_INTN       4'h9
`define PCU_OP_INTX       4'hA
`define PCU_OP_EXC        4'hB
`define PCU_OP_ADDR       4'hC
// Descriptor types
`define PCU_DT_CODE       3'h0
`define PCU_DT_DATA       3'h1
`define PCU_DT_CGATE      3'h2
`define PCU_DT_TGATE      3'h3
`define PCU_DT_IGATE      3'h4
`define PCU_DT_TSS        3'h5
`define PCU_DT_TASKGATE   3'h6
// Descriptor tables
`define PCU_TB_GLOBAL     2'h0
`define PCU_TB_LOCAL      2'h1
`define PCU_TB_INTR       2'h2
`endif

// ---- test/pcu_check_sva.sv ----
// Port assertions for the privilege check unit
`timescale 1ns/1ps
`include "pcu_defines.vh"
module pcu_check_sva (
  input wire        clk,
  input wire        rst,
  input wire        ce,
  input wire        chk_valid,
  input wire [3:0]  chk_op,
  input wire [1:0]  chk_req_priv,
  input wire [1:0]  chk_desc_priv,
  input wire [15:0] chk_seg,
  input wire [15:0] chk_offset,
  input wire        res_valid,
  input wire        res_allow,
  input wire        res_gp_fault,
  input wire        res_task_switch,
  input wire        res_stack_load,
  input wire        res_stack_push,
  input wire [20:0] res_lin_addr,
  input wire [1:0]  res_cur_priv,
  input wire        res_prot_mode,
  input wire        res_v86_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_result_next: assert property (ce && chk_valid |=> res_valid)
    else $error("no result after a request");
  a_no_stray: assert property (ce && !chk_valid |=> !res_valid)
    else $error("result without a request");
  a_one_verdict: assert property (res_valid |-> res_allow != res_gp_fault)
    else $error("allow and fault not exclusive");
  a_rpl_three: assert property (ce && chk_valid && chk_op == `PCU_OP_MEM && res_prot_mode && chk_req_priv == 2'h3
    && chk_desc_priv != 2'h3 |=> res_gp_fault) else $error("weakest request level not enforced");
  a_dpl_three: assert property (ce && chk_valid && chk_op == `PCU_OP_MEM && res_prot_mode
    && chk_desc_priv == 2'h3 |=> res_allow) else $error("open segment refused");
  a_v86_level: assert property (res_v86_mode && $past(res_v86_mode) |-> res_cur_priv == `PCU_PRIV_MAX)
    else $error("v86 task not at level 3");
  a_real_level: assert property (!res_prot_mode && !$past(res_prot_mode) |-> res_cur_priv == 2'h0)
    else $error("real mode not at level 0");
  a_addr_form: assert property (ce |=> res_lin_addr == {1'b0, $past(chk_seg), 4'h0} + {5'h0, $past(chk_offset)})
    else $error("linear address wrong");
  a_push_inward: assert property (res_stack_push |-> res_stack_load && res_allow)
    else $error("push without stack load");
  a_fault_quiet: assert property (res_gp_fault |-> !res_stack_load && !res_task_switch)
    else $error("faulting transfer changed state");
endmodule // pcu_check_sva
bind pcu_privilege_check pcu_check_sva u_sva (.clk, .rst, .ce, .chk_valid, .chk_op, .chk_req_priv, .chk_desc_priv,
  .chk_seg, .chk_offset, .res_valid, .res_allow, .res_gp_fault, .res_task_switch, .res_stack_load, .res_stack_push,
  .res_lin_addr, .res_cur_priv, .res_prot_mode, .res_v86_mode);

// ---- test/pcu_pipe_model.sv ----
// Pipeline side model issuing check requests
`timescale 1ns/1ps
module pcu_pipe_model (
  input  wire        clk,
  output reg         chk_valid,
  output reg  [3:0]  chk_op,
  output reg  [1:0]  chk_req_priv,
  output reg  [1:0]  chk_desc_priv,
  output reg  [2:0]  chk_desc_type,
  output reg  [1:0]  chk_table,
  output reg  [1:0]  chk_target_priv,
  output reg  [9:0]  chk_port,
  output reg  [15:0] chk_seg,
  output reg  [15:0] chk_offset,
  output reg  [31:0] chk_old_sp,
  output reg  [15:0] chk_old_ss
);
  // Idle values at time zero
  initial begin
    {chk_valid, chk_op, chk_req_priv, chk_desc_priv, chk_desc_type, chk_table, chk_target_priv} = 0;
    {chk_port, chk_seg, chk_offset} = 0;
    chk_old_sp = 32'h0000_7ff0;
    chk_old_ss = 16'h0023;
  end
  // One request pulse, port and segment scrambled after release
  task issue(input [3:0] op, input [1:0] rq, dp, input [2:0] ty, input [1:0] tbl, tg, input [9:0] pt,
             input [15:0] sg);
    @(posedge clk);
    chk_valid <= 1'b1;
    {chk_op, chk_req_priv, chk_desc_priv, chk_desc_type, chk_table, chk_target_priv, chk_port} <=
      {op, rq, dp, ty, tbl, tg, pt};
    chk_seg <= sg;
    chk_offset <= {sg[7:0], sg[15:8]};
    @(posedge clk);
    chk_valid <= 1'b0;
    chk_port <= ~pt;
    chk_seg <= ~sg;
    #1;
  endtask
endmodule // pcu_pipe_model

// ---- test/tb_privilege_check_unit.sv ----
// Self-checking bench for the privilege check unit
`timescale 1ns/1ps
`include "pcu_defines.vh"
module tb_privilege_check_unit;
  reg         clk = 0;
  reg         rst = 1;
  reg         ce = 1;
  reg  [7:0]  reg_addr = 0;
  reg  [31:0] reg_wdata = 0;
  reg         reg_wr = 0;
  reg         reg_rd = 0;
  wire [31:0] reg_rdata;
  wire        chk_valid, res_valid, res_allow, res_gp_fault, res_task_switch, res_stack_load, res_stack_push;
  wire [3:0]  chk_op;
  wire [2:0]  chk_desc_type;
  wire [1:0]  chk_req_priv, chk_desc_priv, chk_table, chk_target_priv, res_cur_priv;
  wire [9:0]  chk_port;
  wire [15:0] chk_seg, chk_offset, chk_old_ss, res_ss;
  wire [31:0] chk_old_sp, res_sp;
  wire [20:0] res_lin_addr;
  wire        res_prot_mode, res_v86_mode, res_page_en;
  integer     failures = 0;
  integer     n_checks = 0;
  integer     cycles = 0;
  always #25 clk = ~clk;
  pcu_pipe_model pipe (.clk, .chk_valid, .chk_op, .chk_req_priv, .chk_desc_priv, .chk_desc_type, .chk_table,
    .chk_target_priv, .chk_port, .chk_seg, .chk_offset, .chk_old_sp, .chk_old_ss);
  pcu_privilege_check dut (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .chk_valid,
    .chk_op, .chk_req_priv, .chk_desc_priv, .chk_desc_type, .chk_table, .chk_target_priv, .chk_port, .chk_seg,
    .chk_offset, .chk_old_sp, .chk_old_ss, .res_valid, .res_allow, .res_gp_fault, .res_task_switch,
    .res_stack_load, .res_stack_push, .res_sp, .res_ss, .res_lin_addr, .res_cur_priv, .res_prot_mode,
    .res_v86_mode, .res_page_en);
  // Compare and count
  task cmp(input [31:0] seen, input [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Register bus cycles
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] exp);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, exp);
  endtask
  // Check request with expected verdict
  task chk(input [3:0] op, input [1:0] rq, dp, input [2:0] ty, input [1:0] tbl, tg, input [9:0] pt, input e);
    pipe.issue(op, rq, dp, ty, tbl, tg, pt, 16'h1234);
    cmp({res_valid, res_allow, res_gp_fault}, {1'b1, e, ~e});
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures = failures + 1;
      tally_and_finish;
    end
  end
  integer i;
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(`PCU_REG_CTRL0, `PCU_CTRL0_RST);
    rd(`PCU_REG_FLAGS, `PCU_FLAGS_RST);
    rd(`PCU_REG_STATUS, 32'h0);
    rd(8'h7f, 32'h0);
    $display("test reset done");
    // Level 0 stack prepared before mode entry
    wr(`PCU_REG_STK_SP0, 32'h0001_2340);
    wr(`PCU_REG_STK_SS0, 32'h0000_0010);
    wr(`PCU_REG_CTRL0, 32'h0000_0001);
    rd(`PCU_REG_STATUS, 32'h4);
    for (i = 0; i < 16; i = i + 1)
      chk(`PCU_OP_MEM, i[3:2], i[1:0], `PCU_DT_DATA, `PCU_TB_GLOBAL, 0, 0, i[3:2] <= i[1:0]);
    chk(`PCU_OP_IFSENS, 0, 0, `PCU_DT_CODE, `PCU_TB_GLOBAL, 0, 0, 1);
    chk(`PCU_OP_JMP, 0, 3, `PCU_DT_TSS, `PCU_TB_LOCAL, 3, 0, 0);
    chk(`PCU_OP_JMP, 0, 0, `PCU_DT_TSS, `PCU_TB_GLOBAL, 3, 0, 1);
    cmp(res_task_switch, 1);
    rd(`PCU_REG_STATUS, 32'h7);
    $display("test protected entry done");
    wr(`PCU_REG_FLAGS, 32'h0000_3002);
    rd(`PCU_REG_FLAGS, 32'h0000_0002);
    chk(`PCU_OP_IO, 3, 3, `PCU_DT_DATA, `PCU_TB_GLOBAL, 3, 10'h025, 0);
    wr(`PCU_REG_TSSCFG, 32'h0000_0001);
    chk(`PCU_OP_IO, 3, 3, `PCU_DT_DATA, `PCU_TB_GLOBAL, 3, 10'h025, 0);
    wr(`PCU_REG_BITMAP0 + 8'h01, 32'hffff_ffdf);
    chk(`PCU_OP_IO, 3, 3, `PCU_DT_DATA, `PCU_TB_GLOBAL, 3, 10'h025, 1);
    chk(`PCU_OP_IO, 3, 3, `PCU_DT_DATA, `PCU_TB_GLOBAL, 3, 10'h024, 0);
    chk(`PCU_OP_IFSENS, 3, 3, `PCU_DT_DATA, `PCU_TB_GLOBAL, 3, 0, 0);
    $display("test io privilege done");
    chk(`PCU_OP_JMP, 3, 3, `PCU_DT_DATA, `PCU_TB_GLOBAL, 3, 0, 0);
    chk(`PCU_OP_INTN, 3, 3, `PCU_DT_CGATE, `PCU_TB_INTR, 0, 0, 0);
    chk(`PCU_OP_INTN, 3, 0, `PCU_DT_IGATE, `PCU_TB_INTR, 0, 0, 0);
    chk(`PCU_OP_INTN, 3, 3, `PCU_DT_IGATE, `PCU_TB_INTR, 0, 0, 1);
    cmp({res_stack_load, res_stack_push}, 2'b11);
    cmp(res_sp, 32'h0001_2340);
    cmp(res_ss, 16'h0010);
    rd(`PCU_REG_SAVED_SP, 32'h0000_7ff0);
    rd(`PCU_REG_STATUS, 32'h4);
    wr(`PCU_REG_FLAGS, 32'h0000_3002);
    rd(`PCU_REG_FLAGS, 32'h0000_3002);
    chk(`PCU_OP_FLAGSPP, 3, 3, `PCU_DT_DATA, `PCU_TB_GLOBAL, 0, 0, 1);
    wr(`PCU_REG_FLAGS, 32'h0000_0002);
    chk(`PCU_OP_RET, 3, 3, `PCU_DT_CODE, `PCU_TB_GLOBAL, 3, 0, 1);
    cmp({res_stack_load, res_stack_push}, 2'b10);
    cmp(res_sp, 32'h0000_7ff0);
    $display("test transfers done");
    wr(`PCU_REG_CTRL0, 32'h8000_0001);
    wr(`PCU_REG_FLAGS, 32'h0002_0002);
    pipe.issue(`PCU_OP_ADDR, 3, 3, `PCU_DT_DATA, `PCU_TB_GLOBAL, 3, 0, 16'hf00d);
    cmp(res_lin_addr, {1'b0, 16'hf00d, 4'h0} + 21'h00_0df0);
    cmp({res_v86_mode, res_cur_priv}, 3'b111);
    cmp(res_page_en, 1);
    chk(`PCU_OP_PRIV, 3, 3, `PCU_DT_CODE, `PCU_TB_GLOBAL, 3, 0, 0);
    chk(`PCU_OP_INTN, 3, 3, `PCU_DT_IGATE, `PCU_TB_INTR, 0, 0, 0);
    chk(`PCU_OP_INTX, 3, 3, `PCU_DT_IGATE, `PCU_TB_INTR, 0, 0, 1);
    chk(`PCU_OP_FLAGSPP, 3, 3, `PCU_DT_DATA, `PCU_TB_GLOBAL, 3, 0, 0);
    chk(`PCU_OP_IRET, 3, 3, `PCU_DT_CODE, `PCU_TB_GLOBAL, 3, 0, 0);
    $display("test v86 done");
    tally_and_finish;
  end
endmodule // tb_privilege_check_unit
